// [rtl/sysref_capture_lmfc_align.sv]
// Purpose: Capture reference pulses, blank repeats, align frame and multiframe timing
// Assumes: Reference pulse and external oscillator arrive asynchronously on pins
// Notes: The external oscillator path is only meaningful well below CLOCK/2
`timescale 1ns/10ps
`default_nettype none
module sysref_capture_lmfc_align
	import sysref_align_pkg::*;
(
	input  wire logic             CLOCK,
	input  wire logic             RST_N,
	input  wire logic             SYSREF_IN,
	input  wire logic             PFD_RATE_HIGH,
	input  wire logic             EXT_LO_SEL,
	input  wire logic             EXT_LO_IN,
	output var  logic             DIVIDER_RESET,
	output var  logic             SYSREF_ACCEPTED,
	output var  logic             BLANKING,
	output var  logic             ALIGNED,
	output var  logic             FRAME_TICK,
	output var  logic             LMFC_TICK,
	output var  logic [MF_W-1:0]  LMFC_COUNT,
	output var  logic             LO_I,
	output var  logic             LO_Q
);

	// Synchronisers; first stages read only by second stages
	logic       sref_s1_q;
	logic       sref_s2_q;
	logic       sref_prev_q;
	logic       lo_s1_q;
	logic       lo_s2_q;
	logic       lo_prev_q;

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			sref_s1_q   <= 1'b0;
			sref_s2_q   <= 1'b0;
			sref_prev_q <= 1'b0;
			lo_s1_q     <= 1'b0;
			lo_s2_q     <= 1'b0;
			lo_prev_q   <= 1'b0;
		end else begin
			sref_s1_q   <= SYSREF_IN; // R8
			sref_s2_q   <= sref_s1_q;
			sref_prev_q <= sref_s2_q;
			lo_s1_q     <= EXT_LO_IN;
			lo_s2_q     <= lo_s1_q;
			lo_prev_q   <= lo_s2_q;
		end
	end

	// Edges of a synchronised level against its previous sample
	function automatic logic rose_now(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction

	function automatic logic fell_now(input logic cur, input logic prev);
		return ~cur & prev;
	endfunction

	// Active high: only a low-to-high sample pair counts
	logic sref_rise;
	assign sref_rise = rose_now(sref_s2_q, sref_prev_q); // R8 R13

	// Capture and blanking
	capture_state_t    state_q;
	capture_state_t    state_d;
	logic [BLANK_W-1:0] blank_cnt_q;
	logic [BLANK_W-1:0] blank_cnt_d;
	logic [BLANK_W-1:0] blank_len;
	logic               div_rst_q;
	logic               div_rst_d;
	logic               accept_q;
	logic               accept_d;
	logic               aligned_q;
	logic               aligned_d;
	logic               accept_now;
	logic               blank_q;
	logic               blank_d;

	// Rate fixed by clock plan; source keeps it under the 80 MHz limit
	assign blank_len = PFD_RATE_HIGH ? BLANK_HIGH : BLANK_LOW; // R3 R4 R5

	always_comb begin
		state_d     = state_q;
		blank_cnt_d = blank_cnt_q;
		div_rst_d   = 1'b0;
		accept_d    = 1'b0;
		aligned_d   = aligned_q;
		accept_now  = 1'b0;
		case (state_q)
			ST_WAIT_FIRST: begin
				if (sref_rise) begin
					accept_now  = 1'b1;
					div_rst_d   = 1'b1; // R1
					accept_d    = 1'b1;
					aligned_d   = 1'b1;
					blank_cnt_d = BLANK_RST;
					state_d     = ST_BLANK;
				end
			end
			ST_BLANK: begin
				// Pulses in this state are dropped without trace
				if (blank_cnt_q >= blank_len - 9'h001) begin // R2
					state_d = ST_ARMED;
				end else begin
					blank_cnt_d = blank_cnt_q + 9'h001; // R13
				end
			end
			ST_ARMED: begin
				// Periodic and gapped trains realign on every accepted pulse
				if (sref_rise) begin // R6
					accept_now  = 1'b1;
					accept_d    = 1'b1;
					blank_cnt_d = BLANK_RST; // R13
					state_d     = ST_BLANK;
				end
			end
			default: begin
				state_d     = ST_WAIT_FIRST;
				blank_cnt_d = BLANK_RST;
				aligned_d   = 1'b0;
			end
		endcase
		blank_d = (state_d == ST_BLANK); // R2
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q     <= ST_WAIT_FIRST;
			blank_cnt_q <= BLANK_RST;
			div_rst_q   <= 1'b0;
			accept_q    <= 1'b0;
			aligned_q   <= 1'b0;
			blank_q     <= 1'b0;
		end else begin
			state_q     <= state_d;
			blank_cnt_q <= blank_cnt_d;
			div_rst_q   <= div_rst_d;
			accept_q    <= accept_d;
			aligned_q   <= aligned_d;
			blank_q     <= blank_d;
		end
	end

	// Frame and multiframe timing
	lmfc_pos_t pos_q;
	lmfc_pos_t pos_d;
	logic      frame_tick_q;
	logic      frame_tick_d;
	logic      lmfc_tick_q;
	logic      lmfc_tick_d;

	always_comb begin
		pos_d        = pos_q;
		frame_tick_d = 1'b0;
		lmfc_tick_d  = 1'b0;
		if (accept_now) begin
			// Sampling edge becomes phase zero of frame and multiframe
			pos_d        = LMFC_RST; // R10
			frame_tick_d = 1'b1;
			lmfc_tick_d  = 1'b1;
		end else if (pos_q.cycle_idx == FRAME_LAST) begin
			pos_d.cycle_idx = FRAME_RST;
			frame_tick_d    = 1'b1;
			if (pos_q.frame_idx == MF_LAST) begin
				pos_d.frame_idx = MF_RST;
				lmfc_tick_d     = 1'b1;
			end else begin
				pos_d.frame_idx = pos_q.frame_idx + 3'h1;
			end
		end else begin
			pos_d.cycle_idx = pos_q.cycle_idx + 2'h1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pos_q        <= LMFC_RST;
			frame_tick_q <= 1'b0;
			lmfc_tick_q  <= 1'b0;
		end else begin
			pos_q        <= pos_d;
			frame_tick_q <= frame_tick_d;
			lmfc_tick_q  <= lmfc_tick_d;
		end
	end

	// External oscillator halving; I on rising, Q on falling input edges
	quad_lo_t lo_q;
	quad_lo_t lo_d;

	always_comb begin
		lo_d = lo_q;
		if (!EXT_LO_SEL) begin
			lo_d = QUAD_RST;
		end else if (rose_now(lo_s2_q, lo_prev_q)) begin
			lo_d.i_phase = ~lo_q.i_phase; // R12
		end else if (fell_now(lo_s2_q, lo_prev_q)) begin
			lo_d.q_phase = ~lo_q.q_phase; // R12
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			lo_q <= QUAD_RST;
		end else begin
			lo_q <= lo_d;
		end
	end

	assign DIVIDER_RESET   = div_rst_q;
	assign SYSREF_ACCEPTED = accept_q;
	assign BLANKING        = blank_q;
	assign ALIGNED         = aligned_q;
	assign FRAME_TICK      = frame_tick_q;
	assign LMFC_TICK       = lmfc_tick_q;
	assign LMFC_COUNT      = pos_q.frame_idx;
	assign LO_I            = lo_q.i_phase;
	assign LO_Q            = lo_q.q_phase;

endmodule
`default_nettype wire

// [rtl/sysref_align_pkg.sv]
// Purpose: Constants and types for reference pulse capture and multiframe alignment
// Assumes: CLOCK is the sampling device reference clock, 20 MHz
// Notes: Blanking length derives from the phase-detector reference rate
// Overview of operation
// R1 - The first accepted reference pulse resets the internal clock divider and so forces a synthesizer relock.
// R2 - After the first pulse every further pulse is ignored until 1,024 phase-detector reference periods have passed.
// R3 - Whoever configures the clocks keeps the phase-detector reference below 80 MHz.
// R4 - A 122.88 MHz or 245.76 MHz reference clock gives a 61.44 MHz phase-detector rate, which sets the blanking length.
// R5 - A 153.6 MHz or 307.2 MHz reference clock gives a 76.8 MHz phase-detector rate, which sets the blanking length.
// R6 - Continuous periodic trains, single strobes and gapped periodic trains are all handled.
// R7 - The pulse source produces no runt pulses or glitches when switching the reference on or off.
// R8 - The reference input is active high and is sampled and latched only on reference clock edges.
// R9 - Periodic or gapped trains have a period that is an exact multiple of the multiframe period.
// R10 - The multiframe counter and frame clock align to the edge on which the sampled reference goes from low to high.
// R11 - All chips of a multichip system are driven from one common reference pulse.
// R12 - With an external oscillator selected its signal is divided by two into quadrature phases.
// R13 - Events are found by comparing current and previous samples, and blanking uses a saturating counter restarted per event.
`default_nettype none
package sysref_align_pkg;

	localparam int unsigned CLK_KHZ        = 20000;
	localparam int unsigned PFD_BLANK_PER  = 1024;
	localparam int unsigned PFD_MAX_KHZ    = 80000;
	localparam int unsigned PFD_LOW_KHZ    = 61440;
	localparam int unsigned PFD_HIGH_KHZ   = 76800;

	// Least wait, so round up to whole cycles
	localparam int unsigned BLANK_LOW_CYC  =
		(PFD_BLANK_PER * CLK_KHZ + PFD_LOW_KHZ - 1) / PFD_LOW_KHZ;
	localparam int unsigned BLANK_HIGH_CYC =
		(PFD_BLANK_PER * CLK_KHZ + PFD_HIGH_KHZ - 1) / PFD_HIGH_KHZ;

	localparam int unsigned BLANK_W        = 9;
	localparam logic [BLANK_W-1:0] BLANK_LOW  = BLANK_W'(BLANK_LOW_CYC);
	localparam logic [BLANK_W-1:0] BLANK_HIGH = BLANK_W'(BLANK_HIGH_CYC);
	localparam logic [BLANK_W-1:0] BLANK_RST  = 9'h000;

	localparam int unsigned FRAME_W        = 2;
	localparam int unsigned MF_W           = 3;
	localparam logic [FRAME_W-1:0] FRAME_LAST = 2'h3;
	localparam logic [MF_W-1:0]    MF_LAST    = 3'h7;
	localparam logic [FRAME_W-1:0] FRAME_RST  = 2'h0;
	localparam logic [MF_W-1:0]    MF_RST     = 3'h0;

	typedef enum logic [1:0] {
		ST_WAIT_FIRST = 2'b00,
		ST_BLANK      = 2'b01,
		ST_ARMED      = 2'b11
	} capture_state_t;

	typedef struct packed {
		logic [MF_W-1:0]    frame_idx;
		logic [FRAME_W-1:0] cycle_idx;
	} lmfc_pos_t;

	localparam lmfc_pos_t LMFC_RST = '{frame_idx: MF_RST, cycle_idx: FRAME_RST};

	typedef struct packed {
		logic i_phase;
		logic q_phase;
	} quad_lo_t;

	localparam quad_lo_t QUAD_RST = '{i_phase: 1'b0, q_phase: 1'b0};

endpackage
`default_nettype wire

// [testbench/sysref_capture_lmfc_align_assertions.sv]
// Purpose: Port checks for pulse capture
// Assumes: Pins held two cycles or more
// Notes: Blank length counted in cycles
`timescale 1ns/10ps
`default_nettype none
module sysref_chk
	import sysref_align_pkg::*;
(
	input wire logic            CLOCK,
	input wire logic            RST_N,
	input wire logic            SYSREF_IN,
	input wire logic            PFD_RATE_HIGH,
	input wire logic            EXT_LO_SEL,
	input wire logic            EXT_LO_IN,
	input wire logic            DIVIDER_RESET,
	input wire logic            SYSREF_ACCEPTED,
	input wire logic            BLANKING,
	input wire logic            ALIGNED,
	input wire logic            FRAME_TICK,
	input wire logic            LMFC_TICK,
	input wire logic [MF_W-1:0] LMFC_COUNT,
	input wire logic            LO_I,
	input wire logic            LO_Q
);
	logic [8:0] n_q;
	logic [8:0] n_d;
	always_comb n_d = BLANKING ? n_q + 9'h1 : 9'h0;
	always_ff @(posedge CLOCK) n_q <= RST_N ? n_d : 9'h0;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	property p_div; DIVIDER_RESET == (SYSREF_ACCEPTED && !$past(ALIGNED)); endproperty
	a_div: assert property (p_div) else $error("divider pulse wrong");
	// Fall compares held length, so a short or long window both trip
	property p_len; $fell(BLANKING) |-> n_q == (PFD_RATE_HIGH ? 9'h10b : 9'h14e); endproperty
	a_len: assert property (p_len) else $error("blank length wrong");
	property p_ref; SYSREF_ACCEPTED |-> !$past(BLANKING); endproperty
	a_ref: assert property (p_ref) else $error("accepted while blank");
	property p_in; SYSREF_ACCEPTED |-> $past(SYSREF_IN, 3) && !$past(SYSREF_IN, 4); endproperty
	a_in: assert property (p_in) else $error("accept without rise");
	property p_aln; SYSREF_ACCEPTED |-> FRAME_TICK && LMFC_TICK && LMFC_COUNT == 3'h0; endproperty
	a_aln: assert property (p_aln) else $error("not realigned");
	property p_frm;
		FRAME_TICK ##1 !SYSREF_ACCEPTED [*4] |-> FRAME_TICK && !$past(FRAME_TICK);
	endproperty
	a_frm: assert property (p_frm) else $error("frame period wrong");
	property p_hold; ALIGNED |=> ALIGNED; endproperty
	a_hold: assert property (p_hold) else $error("aligned dropped");
	property p_lo;
		EXT_LO_SEL [*5] |->
			(LO_I != $past(LO_I)) == ($past(EXT_LO_IN, 3) && !$past(EXT_LO_IN, 4));
	endproperty
	a_lo: assert property (p_lo) else $error("lo halving wrong");
	property p_loq;
		EXT_LO_SEL [*5] |->
			(LO_Q != $past(LO_Q)) == (!$past(EXT_LO_IN, 3) && $past(EXT_LO_IN, 4));
	endproperty
	a_loq: assert property (p_loq) else $error("quadrature halving wrong");
	// Multiframe start only ever coincides with a frame start at index zero
	property p_mf; LMFC_TICK == (FRAME_TICK && LMFC_COUNT == 3'h0); endproperty
	a_mf: assert property (p_mf) else $error("multiframe tick wrong");
endmodule
bind sysref_capture_lmfc_align sysref_chk sysref_chk_i (
	.CLOCK(CLOCK), .RST_N(RST_N), .SYSREF_IN(SYSREF_IN), .PFD_RATE_HIGH(PFD_RATE_HIGH),
	.EXT_LO_SEL(EXT_LO_SEL), .EXT_LO_IN(EXT_LO_IN), .DIVIDER_RESET(DIVIDER_RESET),
	.SYSREF_ACCEPTED(SYSREF_ACCEPTED), .BLANKING(BLANKING), .ALIGNED(ALIGNED),
	.FRAME_TICK(FRAME_TICK), .LMFC_TICK(LMFC_TICK), .LMFC_COUNT(LMFC_COUNT), .LO_I(LO_I),
	.LO_Q(LO_Q));
`default_nettype wire

// [testbench/sysref_src.sv]
// Purpose: External pulse and oscillator source
// Assumes: Driven after CLOCK rising edges
// Notes: One source feeds every receiver
`timescale 1ns/10ps
`default_nettype none
module sysref_src (
	input  wire logic clk,
	output var  logic sysref,
	output var  logic lo_in
);
	initial sysref = 1'b0;
	initial lo_in = 1'b0;
	// Whole-cycle levels only, so no runt reaches the pin
	task automatic strobe(input int w);
		@(posedge clk);
		sysref <= 1'b1;
		repeat (w) @(posedge clk);
		sysref <= 1'b0;
	endtask
	task automatic train(input int k, input int per);
		repeat (k) begin
			strobe(2);
			repeat (per - 3) @(posedge clk);
		end
	endtask
	task automatic lo(input int halves);
		repeat (halves) begin
			repeat (4) @(posedge clk);
			lo_in <= ~lo_in;
		end
	endtask
endmodule
`default_nettype wire

// [testbench/sysref_capture_lmfc_align_bench.sv]
// Purpose: Self-checking bench for pulse capture
// Assumes: Each row resets the block first
// Notes: Blank is ceil(1024*20000/pfd_khz)
`timescale 1ns/10ps
`default_nettype none
module sysref_capture_lmfc_align_bench;
	import sysref_align_pkg::*;
	typedef struct {logic p; logic [8:0] len;} row_t;
	row_t rows [2] = '{'{1'b0, 9'h14e}, '{1'b1, 9'h10b}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pfd = 1'b0;
	logic sel = 1'b0;
	wire logic sref;
	wire logic lo_in;
	logic div, acc, blank, aln, ftk, ltk, li, lq, li_p, lq_p;
	logic [MF_W-1:0] cnt;
	int err_total = 0;
	int total_checks = 0;
	int n_acc = 0;
	int ti = 0;
	int tq = 0;
	int n;
	sysref_src sysref_src_i (.clk(clk), .sysref(sref), .lo_in(lo_in));
	sysref_capture_lmfc_align sysref_capture_lmfc_align_i (
		.CLOCK(clk), .RST_N(rst_n), .SYSREF_IN(sref), .PFD_RATE_HIGH(pfd),
		.EXT_LO_SEL(sel), .EXT_LO_IN(lo_in), .DIVIDER_RESET(div), .SYSREF_ACCEPTED(acc),
		.BLANKING(blank), .ALIGNED(aln), .FRAME_TICK(ftk), .LMFC_TICK(ltk),
		.LMFC_COUNT(cnt), .LO_I(li), .LO_Q(lq));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		n_acc += int'(acc === 1'b1);
		ti += int'(li !== li_p);
		tq += int'(lq !== lq_p);
		li_p = li;
		lq_p = lq;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d of %0d checks", err_total, total_checks);
		if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic restart(input logic p);
		@(posedge clk);
		rst_n <= 1'b0;
		pfd <= p;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check(9'({div, acc, blank, aln, cnt}), 9'h000);
		n_acc = 0;
	endtask
	task automatic pulse;
		sysref_src_i.strobe(2);
		n = 0;
		while (acc !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
	endtask
	initial begin
		foreach (rows[r]) begin
			restart(rows[r].p);
			pulse();
			check(9'({acc, div, aln}), 9'h007);
			n = 0;
			while (blank === 1'b1 && n < 400) begin
				@(negedge clk);
				n++;
			end
			check(9'(n), rows[r].len);
			pulse();
			check(9'({acc, div, blank}), 9'h005);
			repeat (30) @(negedge clk);
			pulse();
			check(9'(n_acc), 9'h2);
		end
		// Let the open window close so the held level is accepted once
		repeat (250) @(negedge clk);
		// Level held past the window must not count again
		sysref_src_i.strobe(300);
		repeat (10) @(negedge clk);
		check(9'(n_acc), 9'h3);
		sysref_src_i.train(6, 384);
		sysref_src_i.train(8, 64);
		repeat (10) @(negedge clk);
		check(9'(n_acc), 9'hb);
		@(posedge clk);
		sel <= 1'b1;
		repeat (6) @(negedge clk);
		ti = 0;
		tq = 0;
		// Odd toggle count leaves both phases high, so the deselect clear shows
		sysref_src_i.lo(6);
		repeat (6) @(negedge clk);
		check(9'({ti[3:0], tq[3:0]}), 9'h033);
		check(9'({li, lq}), 9'h003);
		@(posedge clk);
		sel <= 1'b0;
		repeat (3) @(negedge clk);
		check(9'({li, lq}), 9'h000);
		complete_run();
	end
	initial begin
		repeat (12000) @(posedge clk);
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
